// [hw/pwm_action_defines.vh]
`ifndef PWM_ACTION_DEFINES_VH
`define PWM_ACTION_DEFINES_VH

// ************************************************************
// register offsets, byte addresses
// ************************************************************
`define PWM_STATUS_OFS 8'h00
`define PWM_GEN0_CTL_OFS 8'h40
`define PWM_GEN0_A_OFS 8'h60
`define PWM_GEN0_B_OFS 8'h64
`define PWM_GEN1_CTL_OFS 8'h80
`define PWM_GEN1_A_OFS 8'hA0
`define PWM_GEN1_B_OFS 8'hA4
`define PWM_GEN2_CTL_OFS 8'hC0
`define PWM_GEN2_A_OFS 8'hE0
`define PWM_GEN2_B_OFS 8'hE4

// ************************************************************
// output control register fields, low bit of each 2-bit field
// ************************************************************
`define PWM_ACT_ZERO_LSB 0
`define PWM_ACT_LOAD_LSB 2
`define PWM_ACT_CMPA_UP_LSB 4
`define PWM_ACT_CMPA_DN_LSB 6
`define PWM_ACT_CMPB_UP_LSB 8
`define PWM_ACT_CMPB_DN_LSB 10
`define PWM_ACT_CTL_W 12
`define PWM_ACT_CTL_RESET 12'h000

// ************************************************************
// generator control register fields
// ************************************************************
`define PWM_GEN_MODE_BIT 1
`define PWM_GEN_CTL_W 2
`define PWM_GEN_CTL_RESET 2'h0

// ************************************************************
// action encodings
// ************************************************************
`define PWM_ACT_NONE 2'h0
`define PWM_ACT_TOGGLE 2'h1
`define PWM_ACT_LOW 2'h2
`define PWM_ACT_HIGH 2'h3

`endif

// [hw/pwm_event_detect.v]
`timescale 1ns/10ps
`include "pwm_action_defines.vh"

// ************************************************************
// counter event pulses for one generator
// ************************************************************
module pwm_event_detect
#(
  parameter CNT_W = 16
)
(
  input wire tick_i,
  input wire dir_up_i,
  input wire mode_updown_i,
  input wire [CNT_W-1:0] cnt_i,
  input wire [CNT_W-1:0] load_i,
  input wire [CNT_W-1:0] cmp_a_i,
  input wire [CNT_W-1:0] cmp_b_i,
  output wire zero_o,
  output wire load_o,
  output wire cmp_a_up_o,
  output wire cmp_a_dn_o,
  output wire cmp_b_up_o,
  output wire cmp_b_dn_o
);

  wire going_up;
  wire hit_a;
  wire hit_b;

  // down-only mode counts down whatever the direction input says
  assign going_up = mode_updown_i & dir_up_i; // RQ7 RQ8

  // a compare above load can never match
  assign hit_a = tick_i & (cnt_i == cmp_a_i) & (cmp_a_i <= load_i); // RQ15
  assign hit_b = tick_i & (cnt_i == cmp_b_i) & (cmp_b_i <= load_i); // RQ15

  // counter events
  assign zero_o = tick_i & (cnt_i == {CNT_W{1'b0}});
  assign load_o = tick_i & (cnt_i == load_i);
  assign cmp_a_up_o = hit_a & going_up; // RQ7
  assign cmp_a_dn_o = hit_a & ~going_up; // RQ8
  assign cmp_b_up_o = hit_b & going_up; // RQ7
  assign cmp_b_dn_o = hit_b & ~going_up; // RQ8

endmodule

// [hw/pwm_output_action.v]
`timescale 1ns/10ps
`include "pwm_action_defines.vh"

// ************************************************************
// output level for one pwm output
// ************************************************************
module pwm_output_action
#(
  parameter CMP_B_FIRST = 0
)
(
  input wire clk_i,
  input wire reset_i,
  input wire [`PWM_ACT_CTL_W-1:0] ctl_i,
  input wire zero_i,
  input wire load_i,
  input wire cmp_a_up_i,
  input wire cmp_a_dn_i,
  input wire cmp_b_up_i,
  input wire cmp_b_dn_i,
  output reg level_ff
);

  reg [1:0] act;
  reg nxt_level;
  wire cmp_a;
  wire cmp_b;

  assign cmp_a = cmp_a_up_i | cmp_a_dn_i;
  assign cmp_b = cmp_b_up_i | cmp_b_dn_i;

  // pick one action; zero and load outrank both comparators
  always @*
  begin
    act = `PWM_ACT_NONE;
    if (zero_i)
      act = ctl_i[`PWM_ACT_ZERO_LSB+1:`PWM_ACT_ZERO_LSB]; // RQ5 RQ9
    else if (load_i)
      act = ctl_i[`PWM_ACT_LOAD_LSB+1:`PWM_ACT_LOAD_LSB]; // RQ4 RQ9
    else if (cmp_a && cmp_b && CMP_B_FIRST != 0)
      act = cmp_b_up_i ? ctl_i[`PWM_ACT_CMPB_UP_LSB+1:`PWM_ACT_CMPB_UP_LSB]
                       : ctl_i[`PWM_ACT_CMPB_DN_LSB+1:`PWM_ACT_CMPB_DN_LSB]; // RQ10
    else if (cmp_a)
      act = cmp_a_up_i ? ctl_i[`PWM_ACT_CMPA_UP_LSB+1:`PWM_ACT_CMPA_UP_LSB]
                       : ctl_i[`PWM_ACT_CMPA_DN_LSB+1:`PWM_ACT_CMPA_DN_LSB]; // RQ3 RQ2 RQ13
    else if (cmp_b)
      act = cmp_b_up_i ? ctl_i[`PWM_ACT_CMPB_UP_LSB+1:`PWM_ACT_CMPB_UP_LSB]
                       : ctl_i[`PWM_ACT_CMPB_DN_LSB+1:`PWM_ACT_CMPB_DN_LSB]; // RQ1 RQ14
  end

  // decode of the chosen action
  always @*
  begin
    case (act)
      `PWM_ACT_TOGGLE: nxt_level = ~level_ff; // RQ6
      `PWM_ACT_LOW: nxt_level = 1'b0; // RQ6
      `PWM_ACT_HIGH: nxt_level = 1'b1; // RQ6
      default: nxt_level = level_ff; // RQ16
    endcase
  end

  // level holds between events
  always @(posedge clk_i)
  begin
    if (reset_i)
      level_ff <= 1'b0;
    else
      level_ff <= nxt_level; // RQ16
  end

endmodule

// [hw/pwm_action_top.v]
// Overview of operation
// RQ1 - compare B match counting up applies field 9:8.
// RQ2 - compare A match counting down applies field 7:6.
// RQ3 - compare A match counting up applies field 5:4.
// RQ4 - counter at load value applies field 3:2.
// RQ5 - counter at zero applies field 1:0.
// RQ6 - action codes: 0 hold, 1 toggle, 2 low, 3 high.
// RQ7 - up-count compare events occur only when the mode bit selects up/down.
// RQ8 - down mode gives four events, up/down mode gives all six.
// RQ9 - zero or load action wins over any coinciding compare action.
// RQ10 - on output B, compare B wins over a coinciding compare A.
// RQ11 - each B output is driven by its own B control register.
// RQ12 - B output depends only on zero, load and compare pulses of its generator.
// RQ13 - on output A, compare A wins over a coinciding compare B.
// RQ14 - compare B match counting down applies field 11:10.
// RQ15 - no compare match when compare value exceeds load value.
// RQ16 - B registers share A field layout; outputs hold between events.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "pwm_action_defines.vh"

module pwm_action_top
#(
  parameter CNT_W = 16,
  parameter NUM_GEN = 3
)
(
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_ff,
  input wire [NUM_GEN-1:0] cnt_tick_i,
  input wire [NUM_GEN-1:0] cnt_dir_up_i,
  input wire [NUM_GEN*CNT_W-1:0] cnt_value_i,
  input wire [NUM_GEN*CNT_W-1:0] load_value_i,
  input wire [NUM_GEN*CNT_W-1:0] cmp_a_value_i,
  input wire [NUM_GEN*CNT_W-1:0] cmp_b_value_i,
  output wire [NUM_GEN-1:0] gen_output_a_o,
  output wire [NUM_GEN-1:0] gen_output_b_o
);

  // ************************************************************
  // register storage
  // ************************************************************

  // per generator control words; arrays keep the read mux a loop
  reg [`PWM_GEN_CTL_W-1:0] generator_control_ff [0:NUM_GEN-1];
  reg [`PWM_ACT_CTL_W-1:0] output_a_control_ff [0:NUM_GEN-1];
  reg [`PWM_ACT_CTL_W-1:0] output_b_control_ff [0:NUM_GEN-1];
  reg [31:0] nxt_rdata;
  integer i;

  // ************************************************************
  // per generator logic
  // ************************************************************

  genvar g;
  generate
    for (g = 0; g < NUM_GEN; g = g + 1)
    begin : gen_blk
      // offsets of this generator's three registers
      localparam [7:0] CTL_OFS = (g == 0) ? `PWM_GEN0_CTL_OFS :
                                 (g == 1) ? `PWM_GEN1_CTL_OFS : `PWM_GEN2_CTL_OFS;
      localparam [7:0] A_OFS = (g == 0) ? `PWM_GEN0_A_OFS :
                               (g == 1) ? `PWM_GEN1_A_OFS : `PWM_GEN2_A_OFS;
      localparam [7:0] B_OFS = (g == 0) ? `PWM_GEN0_B_OFS :
                               (g == 1) ? `PWM_GEN1_B_OFS : `PWM_GEN2_B_OFS; // RQ11

      wire ev_zero;
      wire ev_load;
      wire ev_a_up;
      wire ev_a_dn;
      wire ev_b_up;
      wire ev_b_dn;

      // generator control write, the low two bits are kept, bit 1 is the mode bit
      always @(posedge clk_i)
      begin
        if (reset_i)
          generator_control_ff[g] <= `PWM_GEN_CTL_RESET;
        else if (wr_i && addr_i == CTL_OFS)
          generator_control_ff[g] <= wdata_i[`PWM_GEN_CTL_W-1:0];
      end

      // output A control write, reserved bits dropped
      always @(posedge clk_i)
      begin
        if (reset_i)
          output_a_control_ff[g] <= `PWM_ACT_CTL_RESET;
        else if (wr_i && addr_i == A_OFS)
          output_a_control_ff[g] <= wdata_i[`PWM_ACT_CTL_W-1:0];
      end

      // output B control write, same layout as A
      always @(posedge clk_i)
      begin
        if (reset_i)
          output_b_control_ff[g] <= `PWM_ACT_CTL_RESET;
        else if (wr_i && addr_i == B_OFS)
          output_b_control_ff[g] <= wdata_i[`PWM_ACT_CTL_W-1:0]; // RQ11 RQ16
      end

      // counter and comparator pulses of this generator only
      pwm_event_detect #(
        .CNT_W(CNT_W)
      ) u_events (
        .tick_i(cnt_tick_i[g]),
        .dir_up_i(cnt_dir_up_i[g]),
        .mode_updown_i(generator_control_ff[g][`PWM_GEN_MODE_BIT]), // RQ7 RQ8
        .cnt_i(cnt_value_i[g*CNT_W +: CNT_W]),
        .load_i(load_value_i[g*CNT_W +: CNT_W]),
        .cmp_a_i(cmp_a_value_i[g*CNT_W +: CNT_W]),
        .cmp_b_i(cmp_b_value_i[g*CNT_W +: CNT_W]),
        .zero_o(ev_zero),
        .load_o(ev_load),
        .cmp_a_up_o(ev_a_up),
        .cmp_a_dn_o(ev_a_dn),
        .cmp_b_up_o(ev_b_up),
        .cmp_b_dn_o(ev_b_dn)
      );

      // output A: compare A outranks compare B
      pwm_output_action #(
        .CMP_B_FIRST(0)
      ) u_out_a (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ctl_i(output_a_control_ff[g]),
        .zero_i(ev_zero),
        .load_i(ev_load),
        .cmp_a_up_i(ev_a_up),
        .cmp_a_dn_i(ev_a_dn),
        .cmp_b_up_i(ev_b_up),
        .cmp_b_dn_i(ev_b_dn),
        .level_ff(gen_output_a_o[g]) // RQ13
      );

      // output B: compare B outranks compare A
      pwm_output_action #(
        .CMP_B_FIRST(1)
      ) u_out_b (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ctl_i(output_b_control_ff[g]), // RQ11
        .zero_i(ev_zero), // RQ12
        .load_i(ev_load), // RQ12
        .cmp_a_up_i(ev_a_up), // RQ12
        .cmp_a_dn_i(ev_a_dn),
        .cmp_b_up_i(ev_b_up),
        .cmp_b_dn_i(ev_b_dn),
        .level_ff(gen_output_b_o[g]) // RQ10
      );
    end
  endgenerate

  // ************************************************************
  // register read path
  // ************************************************************

  // read mux; unmapped addresses and reserved bits read zero
  always @*
  begin
    nxt_rdata = 32'h00000000;
    if (addr_i == `PWM_STATUS_OFS)
      nxt_rdata = {{(32-2*NUM_GEN){1'b0}}, gen_output_b_o, gen_output_a_o};
    for (i = 0; i < NUM_GEN; i = i + 1)
    begin
      if (addr_i == ((i == 0) ? `PWM_GEN0_CTL_OFS : (i == 1) ? `PWM_GEN1_CTL_OFS : `PWM_GEN2_CTL_OFS))
        nxt_rdata = {{(32-`PWM_GEN_CTL_W){1'b0}}, generator_control_ff[i]};
      if (addr_i == ((i == 0) ? `PWM_GEN0_A_OFS : (i == 1) ? `PWM_GEN1_A_OFS : `PWM_GEN2_A_OFS))
        nxt_rdata = {{(32-`PWM_ACT_CTL_W){1'b0}}, output_a_control_ff[i]};
      if (addr_i == ((i == 0) ? `PWM_GEN0_B_OFS : (i == 1) ? `PWM_GEN1_B_OFS : `PWM_GEN2_B_OFS))
        nxt_rdata = {{(32-`PWM_ACT_CTL_W){1'b0}}, output_b_control_ff[i]};
    end
  end

  // read data stands for exactly the cycle after the strobe
  always @(posedge clk_i)
  begin
    if (reset_i)
      rdata_ff <= 32'h00000000;
    else if (rd_i)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 32'h00000000;
  end

endmodule

// [sim/pwm_action_asserts.sv]
`timescale 1ns/10ps
`include "pwm_action_defines.vh"

// ************************************************************
// generator 0 output checks and the idle read data check
// ************************************************************
module pwm_action_asserts
#(
  parameter CNT_W = 16,
  parameter NUM_GEN = 3
)
(
  input wire clk_i,
  input wire reset_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_ff,
  input wire [NUM_GEN-1:0] cnt_tick_i,
  input wire [NUM_GEN-1:0] cnt_dir_up_i,
  input wire [NUM_GEN*CNT_W-1:0] cnt_value_i,
  input wire [NUM_GEN*CNT_W-1:0] load_value_i,
  input wire [NUM_GEN*CNT_W-1:0] cmp_a_value_i,
  input wire [NUM_GEN*CNT_W-1:0] cmp_b_value_i,
  input wire [NUM_GEN-1:0] gen_output_a_o,
  input wire [NUM_GEN-1:0] gen_output_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [11:0] a0_ff;
  logic [11:0] b0_ff;
  logic m0_ff;
  wire ev = cnt_tick_i[0];
  wire [CNT_W-1:0] c = cnt_value_i[CNT_W-1:0];
  wire [CNT_W-1:0] ld = load_value_i[CNT_W-1:0];
  wire [CNT_W-1:0] ca = cmp_a_value_i[CNT_W-1:0];
  wire [CNT_W-1:0] cb = cmp_b_value_i[CNT_W-1:0];
  // shadow of generator 0 control, so checks see what software asked for
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      a0_ff <= 12'h000;
      b0_ff <= 12'h000;
      m0_ff <= 1'b0;
    end
    else if (wr_i)
    begin
      if (addr_i == `PWM_GEN0_A_OFS) a0_ff <= wdata_i[11:0];
      if (addr_i == `PWM_GEN0_B_OFS) b0_ff <= wdata_i[11:0];
      if (addr_i == `PWM_GEN0_CTL_OFS) m0_ff <= wdata_i[1];
    end
  end
  property p_rd_idle;
    !rd_i |=> rdata_ff == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_hold_a;
    !ev |=> $stable(gen_output_a_o[0]);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("output a moved without event");
  property p_hold_b;
    !ev |=> $stable(gen_output_b_o[0]);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("output b moved without event");
  property p_zero_high;
    ev && c == 0 && b0_ff[1:0] == 2'h3 |=> gen_output_b_o[0];
  endproperty
  a_zero_high: assert property (p_zero_high) else $error("zero high action missed");
  property p_zero_low;
    ev && c == 0 && a0_ff[1:0] == 2'h2 |=> !gen_output_a_o[0];
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero low action missed");
  property p_toggle;
    ev && c == 0 && b0_ff[1:0] == 2'h1 |=> gen_output_b_o[0] != $past(gen_output_b_o[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle action missed");
  property p_load_high;
    ev && c != 0 && c == ld && a0_ff[3:2] == 2'h3 |=> gen_output_a_o[0];
  endproperty
  a_load_high: assert property (p_load_high) else $error("load action missed");
  property p_cmpa_up;
    ev && c != 0 && c != ld && c == ca && ca <= ld && m0_ff && cnt_dir_up_i[0] && a0_ff[5:4] == 2'h3
      |=> gen_output_a_o[0];
  endproperty
  a_cmpa_up: assert property (p_cmpa_up) else $error("compare a up action missed");
  property p_gt_load;
    ev && c != 0 && c == ca && ca > ld && c != cb |=> $stable(gen_output_a_o[0]);
  endproperty
  a_gt_load: assert property (p_gt_load) else $error("match above load acted");
  c_zero: cover property (ev && c == 0);
  c_both: cover property (ev && c == ca && c == cb);
  c_read: cover property (rd_i);
endmodule

// [sim/pwm_action_top_tb_top.sv]
`timescale 1ns/10ps
`include "pwm_action_defines.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end

// ************************************************************
// action logic bench
// ************************************************************
module pwm_action_top_tb_top;
  logic clk_i = 0;
  logic reset_i = 1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic [2:0] cnt_tick_i = 3'h0;
  logic [2:0] cnt_dir_up_i = 3'h0;
  logic [47:0] cnt_value_i = 48'h0;
  logic [47:0] load_value_i = {3{16'h0064}};
  logic [47:0] cmp_a_value_i = 48'h0;
  logic [47:0] cmp_b_value_i = 48'h0;
  wire [31:0] rdata_ff;
  wire [2:0] gen_output_a_o;
  wire [2:0] gen_output_b_o;
  logic [2:0] exp_a = 3'h0;
  logic [2:0] exp_b = 3'h0;
  int fails = 0;
  int check_count = 0;
  pwm_action_top dut (.*);
  // free running clock
  initial forever #20 clk_i = ~clk_i;
  // hang guard, far beyond the roughly 150 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
  function logic nx(input logic [1:0] k, input logic l);
    nx = (k == 2'h0) ? l : (k == 2'h1) ? !l : k[0];
  endfunction
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_ff, e)
  endtask
  // one counter tick on generator g, then both output vectors judged
  task ev(input int g, input logic [15:0] c, input logic [15:0] ca, input logic [15:0] cb, input logic up);
    @(posedge clk_i);
    cnt_tick_i <= 3'h1 << g;
    cnt_value_i <= {3{c}};
    cmp_a_value_i <= {3{ca}};
    cmp_b_value_i <= {3{cb}};
    cnt_dir_up_i <= {3{up}};
    @(posedge clk_i);
    cnt_tick_i <= 3'h0;
    #1;
    `CHK(gen_output_a_o, exp_a)
    `CHK(gen_output_b_o, exp_b)
  endtask
  task t_regs();
    rd(8'h64, 32'h0);
    rd(8'h10, 32'h0);
    for (int g = 0; g < 3; g++) wr(8'h64 + 8'(g * 64), 32'hFFFF_F5A5 ^ g);
    for (int g = 0; g < 3; g++) rd(8'h64 + 8'(g * 64), 32'h5A5 ^ g);
    for (int g = 0; g < 3; g++) wr(8'h64 + 8'(g * 64), 32'h0);
  endtask
  task t_codes();
    logic [1:0] k [7];
    k = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h64, {30'h0, k[i]});
      exp_b[0] = nx(k[i], exp_b[0]);
      ev(0, 16'h0, 16'h28, 16'h3C, 1'b0);
    end
  endtask
  task t_fields();
    logic [15:0] cs [6];
    logic [5:0] ups;
    cs = '{16'h0, 16'h64, 16'h28, 16'h28, 16'h3C, 16'h3C};
    ups = 6'b010100;
    wr(8'h80, 32'h2);
    rd(8'h80, 32'h2);
    for (int f = 0; f < 6; f++)
      for (int v = 3; v >= 2; v--)
      begin
        wr(8'hA0, v << (2 * f));
        exp_a[1] = v[0];
        ev(1, cs[f], 16'h28, 16'h3C, ups[f]);
      end
  endtask
  task t_mode();
    wr(8'hE0, 32'h030);
    ev(2, 16'h28, 16'h28, 16'h3C, 1'b1);
    wr(8'hE0, 32'h0C0);
    exp_a[2] = 1'b1;
    ev(2, 16'h28, 16'h28, 16'h3C, 1'b1);
    wr(8'hE0, 32'h200);
    ev(2, 16'h3C, 16'h28, 16'h3C, 1'b1);
    // only generator 2 B may follow its own B control word
    wr(8'hE4, 32'h3);
    exp_b[2] = 1'b1;
    ev(2, 16'h0, 16'h28, 16'h3C, 1'b1);
  endtask
  task t_prio();
    wr(8'h40, 32'h2);
    wr(8'h60, 32'h230);
    wr(8'h64, 32'h320);
    exp_a[0] = 1'b1;
    exp_b[0] = 1'b1;
    ev(0, 16'h32, 16'h32, 16'h32, 1'b1);
    wr(8'h60, 32'h0C2);
    exp_a[0] = 1'b0;
    ev(0, 16'h0, 16'h0, 16'h3C, 1'b0);
    wr(8'h60, 32'h08C);
    exp_a[0] = 1'b1;
    ev(0, 16'h64, 16'h64, 16'h3C, 1'b0);
    wr(8'h60, 32'h080);
    ev(0, 16'h78, 16'h78, 16'h3C, 1'b0);
    // status word shows the held levels of every output
    rd(8'h00, {26'h0, exp_b, exp_a});
  endtask
  // reset, then every scenario in turn
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_codes();
    t_fields();
    t_mode();
    t_prio();
    give_verdict();
  end
endmodule

bind pwm_action_top pwm_action_asserts #(.CNT_W(CNT_W), .NUM_GEN(NUM_GEN)) u_chk (.*);
